// ---- src/gpcd_ports.sv ----
// Port C and port D GPIO with direction, port C LED drive and pin sharing.
// Assumes pins arrive asynchronously; peripherals sit on CLK.
//
// Overview of operation
// [R01] Port C eight-bit read/write data latch
// [R02] Port C latch untouched by reset
// [R03] Port C direction one drives, zero inputs
// [R04] Reset clears port C direction bits
// [R05] Port C read: latch if output, else pin
// [R06] Data writes always update the latch
// [R07] Two bits hand port C nibbles to LCD
// [R08] LED drive bit acts only on outputs
// [R09] Port D eight-bit latch survives reset
// [R10] Port D direction; reset clears it
// [R11] Port D read: latch if output, else pin
// [R12] Keypad enable takes port D pins 7..4
// [R13] I2C enable makes SDA/SCL open drain
// [R14] Timer 2 all-ones prescale takes its pin
// [R15] Timer 1 all-ones prescale takes its pin
// [R16] SPI enable takes four port D pins
// [R17] RTC trim enable takes two pins
// [R18] Software writes data before setting direction
// [R19] Software enables one sharer per pin
// [R20] Fixed priority resolves multiple sharers
`timescale 1ns/1ns
`default_nettype none
module gpcd_ports (
    input wire logic CLK,
    input wire logic NRST,
    input wire gpcd_pkg::gpcd_bus_s BUS,
    output logic [7:0] RDATA,
    input wire logic [7:0] PORTC_IN,
    output gpcd_pkg::gpcd_pin_drv_s PORTC_DRV,
    output logic [7:0] PORTC_LED_SINK,
    output logic [1:0] LCD_NIBBLE_EN,
    input wire logic [7:0] PORTD_IN,
    output gpcd_pkg::gpcd_pin_drv_s PORTD_DRV,
    input wire logic [3:0] KEYPAD_IRQ_ENABLE,
    input wire logic [2:0] TIMER1_PRESCALE,
    input wire logic [2:0] TIMER2_PRESCALE,
    input wire logic I2C_SDA_LOW,
    input wire logic I2C_SCL_LOW,
    input wire logic SPI_SCK_OUT,
    input wire logic SPI_SCK_OE,
    input wire logic SPI_MOSI_OUT,
    input wire logic SPI_MOSI_OE,
    input wire logic SPI_MISO_OUT,
    input wire logic SPI_MISO_OE,
    input wire logic RTC_TRIM_OUT_VAL,
    output logic [7:0] PORTD_PIN_LEVEL
);
    import gpcd_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] portc_data_latch; // Port C output latch, no reset
    logic [7:0] portd_data_latch; // Port D output latch, no reset
    logic [7:0] portc_direction; // Port C direction
    logic [7:0] portd_direction; // Port D direction
    logic [7:0] portc_led_drive_enable; // Port C high-sink enables
    logic [7:0] option_reg_two; // LCD nibble selects
    logic [7:0] alt_enable; // Alternate function enables
    logic [PIN_SYNC_STAGES-1:0] sync_c [8]; // Port C pin synchroniser
    logic [PIN_SYNC_STAGES-1:0] sync_d [8]; // Port D pin synchroniser
    logic [7:0] pin_c; // Filtered port C level
    logic [7:0] pin_d; // Filtered port D level
    logic [7:0] next_rdata; // Read mux output
    logic [7:0] next_d_val; // Port D drive value
    logic [7:0] next_d_oe_n; // Port D enable, low = drive
    logic [7:0] next_c_oe_n; // Port C enable, low = drive
    logic [7:0] keypad_take; // Keypad owned pins
    logic t1_ext; // Timer 1 external clock selected
    logic t2_ext; // Timer 2 external clock selected
    logic [1:0] lcd_sel; // LCD nibble selects

    assign t1_ext = (TIMER1_PRESCALE == 3'h7) | alt_enable[ALT_T1]; // R15
    assign t2_ext = (TIMER2_PRESCALE == 3'h7) | alt_enable[ALT_T2]; // R14
    assign keypad_take = {KEYPAD_IRQ_ENABLE, 4'h0}; // R12
    assign lcd_sel = {option_reg_two[OPT_UPPER_LCD], option_reg_two[OPT_LOWER_LCD]};

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Shift each pin through three stages; accept when last two agree
    always_ff @(posedge CLK) begin
        for (int i = 0; i < 8; i++) begin
            sync_c[i] <= {sync_c[i][PIN_SYNC_STAGES-2:0], PORTC_IN[i]};
            sync_d[i] <= {sync_d[i][PIN_SYNC_STAGES-2:0], PORTD_IN[i]};
        end
    end

    // Filtered levels; a stable reading only counts when stages agree
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            pin_c <= 8'h00;
            pin_d <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (sync_c[i][1] == sync_c[i][2]) begin
                    pin_c[i] <= sync_c[i][2];
                end
                if (sync_d[i][1] == sync_d[i][2]) begin
                    pin_d[i] <= sync_d[i][2];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Data latches
    // ----------------------------------------------------------------
    // Latches have no reset and take every write
    always_ff @(posedge CLK) begin
        if (BUS.wr && BUS.addr == ADDR_PORTC_DATA) begin
            portc_data_latch <= BUS.wdata; // R01 R02 R06
        end
        if (BUS.wr && BUS.addr == ADDR_PORTD_DATA) begin
            portd_data_latch <= BUS.wdata; // R09 R06
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Direction, LED and configuration registers
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            portc_direction <= RST_DIR; // R04
            portd_direction <= RST_DIR; // R10
            portc_led_drive_enable <= RST_LED;
            option_reg_two <= RST_CFG;
            alt_enable <= RST_CFG;
        end else if (BUS.wr) begin
            unique case (BUS.addr)
                ADDR_PORTC_DIR: portc_direction <= BUS.wdata;
                ADDR_PORTD_DIR: portd_direction <= BUS.wdata;
                ADDR_PORTC_LED: portc_led_drive_enable <= BUS.wdata;
                ADDR_OPTION_TWO: option_reg_two <= {6'h00, BUS.wdata[1:0]}; // R07
                ADDR_ALT_ENABLE: alt_enable <= {3'h0, BUS.wdata[4:0]};
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Mix latch and pin per direction bit
    always_comb begin
        unique case (BUS.addr)
            ADDR_PORTC_DATA: next_rdata = (portc_direction & portc_data_latch)
                | (~portc_direction & pin_c); // R05
            ADDR_PORTD_DATA: next_rdata = (portd_direction & portd_data_latch)
                | (~portd_direction & pin_d); // R11
            ADDR_PORTC_DIR: next_rdata = portc_direction;
            ADDR_PORTD_DIR: next_rdata = portd_direction;
            ADDR_PORTC_LED: next_rdata = portc_led_drive_enable;
            ADDR_OPTION_TWO: next_rdata = option_reg_two;
            ADDR_ALT_ENABLE: next_rdata = alt_enable;
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            RDATA <= 8'h00;
        end else if (BUS.rd) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Port C pin drive
    // ----------------------------------------------------------------
    // Direction drives; LCD nibbles release the pins
    always_comb begin
        next_c_oe_n = ~portc_direction; // R03
        if (lcd_sel[1]) begin
            next_c_oe_n[7:4] = 4'hF; // R07
        end
        if (lcd_sel[0]) begin
            next_c_oe_n[3:0] = 4'hF; // R07
        end
    end

    // Registered port C outputs
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            PORTC_DRV <= '{val: 8'h00, oe_n: 8'hFF};
            PORTC_LED_SINK <= 8'h00;
            LCD_NIBBLE_EN <= 2'h0;
        end else begin
            PORTC_DRV <= '{val: portc_data_latch, oe_n: next_c_oe_n};
            PORTC_LED_SINK <= portc_led_drive_enable & ~next_c_oe_n; // R08
            LCD_NIBBLE_EN <= lcd_sel;
        end
    end

    // ----------------------------------------------------------------
    // Port D pin drive
    // ----------------------------------------------------------------
    // Lowest priority first; later overrides win (I2C highest)
    always_comb begin
        next_d_val = portd_data_latch;
        next_d_oe_n = ~portd_direction; // R10
        // Keypad pins are inputs to the interrupt module
        next_d_oe_n = next_d_oe_n | keypad_take; // R12 R20
        if (t1_ext) begin
            next_d_oe_n[PD_TMR1_CLK] = 1'b1; // R15
        end
        if (t2_ext) begin
            next_d_oe_n[PD_TMR2_CLK] = 1'b1; // R14
        end
        if (alt_enable[ALT_RTC]) begin
            next_d_val[PD_TMR1_CLK] = RTC_TRIM_OUT_VAL; // R17
            next_d_oe_n[PD_TMR1_CLK] = 1'b0;
            next_d_oe_n[PD_TMR2_CLK] = 1'b1; // R17
        end
        if (alt_enable[ALT_SPI]) begin
            next_d_val[PD_SCK] = SPI_SCK_OUT; // R16
            next_d_oe_n[PD_SCK] = ~SPI_SCK_OE;
            next_d_val[PD_MOSI] = SPI_MOSI_OUT;
            next_d_oe_n[PD_MOSI] = ~SPI_MOSI_OE;
            next_d_val[PD_MISO] = SPI_MISO_OUT;
            next_d_oe_n[PD_MISO] = ~SPI_MISO_OE;
            next_d_oe_n[PD_SS] = 1'b1;
        end
        if (alt_enable[ALT_I2C]) begin
            next_d_val[PD_SDA] = 1'b0; // R13 R20
            next_d_oe_n[PD_SDA] = ~I2C_SDA_LOW;
            next_d_val[PD_SCL] = 1'b0;
            next_d_oe_n[PD_SCL] = ~I2C_SCL_LOW;
        end
    end

    // Registered port D outputs
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            PORTD_DRV <= '{val: 8'h00, oe_n: 8'hFF};
            PORTD_PIN_LEVEL <= 8'h00;
        end else begin
            PORTD_DRV <= '{val: next_d_val, oe_n: next_d_oe_n};
            PORTD_PIN_LEVEL <= pin_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_dir_reset;
        @(posedge CLK) !NRST |=> (portc_direction == 8'h00 && portd_direction == 8'h00);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared"); // R04

    property p_latch_write;
        @(posedge CLK) BUS.wr && BUS.addr == ADDR_PORTC_DATA
            |=> portc_data_latch == $past(BUS.wdata);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("port C latch missed"); // R06

    property p_latch_keep;
        @(posedge CLK) !NRST && !(BUS.wr && BUS.addr == ADDR_PORTD_DATA)
            |=> $stable(portd_data_latch);
    endproperty
    a_latch_keep: assert property (p_latch_keep) else $error("port D latch changed"); // R09

    property p_read_c;
        @(posedge CLK) disable iff (!NRST) BUS.rd && BUS.addr == ADDR_PORTC_DATA
            |=> RDATA == (($past(portc_direction) & $past(portc_data_latch))
                | (~$past(portc_direction) & $past(pin_c)));
    endproperty
    a_read_c: assert property (p_read_c) else $error("port C read wrong"); // R05

    property p_read_d;
        @(posedge CLK) disable iff (!NRST) BUS.rd && BUS.addr == ADDR_PORTD_DATA
            |=> RDATA == (($past(portd_direction) & $past(portd_data_latch))
                | (~$past(portd_direction) & $past(pin_d)));
    endproperty
    a_read_d: assert property (p_read_d) else $error("port D read wrong"); // R11

    property p_led_output;
        @(posedge CLK) disable iff (!NRST) (PORTC_LED_SINK & PORTC_DRV.oe_n) == 8'h00;
    endproperty
    a_led_output: assert property (p_led_output) else $error("LED on input pin"); // R08

    property p_lcd_upper;
        @(posedge CLK) disable iff (!NRST) option_reg_two[OPT_UPPER_LCD]
            |=> PORTC_DRV.oe_n[7:4] == 4'hF;
    endproperty
    a_lcd_upper: assert property (p_lcd_upper) else $error("LCD nibble driven"); // R07

    property p_keypad;
        @(posedge CLK) disable iff (!NRST) KEYPAD_IRQ_ENABLE[3] && !alt_enable[ALT_I2C]
            && !alt_enable[ALT_RTC] |=> PORTD_DRV.oe_n[PD_TMR2_CLK];
    endproperty
    a_keypad: assert property (p_keypad) else $error("keypad pin driven"); // R12

    property p_i2c;
        @(posedge CLK) disable iff (!NRST) alt_enable[ALT_I2C]
            |=> !PORTD_DRV.val[PD_SDA] && !PORTD_DRV.val[PD_SCL];
    endproperty
    a_i2c: assert property (p_i2c) else $error("I2C pin drives high"); // R13

    property p_t2;
        @(posedge CLK) disable iff (!NRST) TIMER2_PRESCALE == 3'h7 && !alt_enable[ALT_RTC]
            |=> PORTD_DRV.oe_n[PD_TMR2_CLK];
    endproperty
    a_t2: assert property (p_t2) else $error("timer 2 pin driven"); // R14

    property p_t1;
        @(posedge CLK) disable iff (!NRST) TIMER1_PRESCALE == 3'h7 && !alt_enable[ALT_RTC]
            |=> PORTD_DRV.oe_n[PD_TMR1_CLK];
    endproperty
    a_t1: assert property (p_t1) else $error("timer 1 pin driven"); // R15

    property p_spi;
        @(posedge CLK) disable iff (!NRST) alt_enable[ALT_SPI]
            |=> PORTD_DRV.oe_n[PD_SS] && PORTD_DRV.val[PD_SCK] == $past(SPI_SCK_OUT);
    endproperty
    a_spi: assert property (p_spi) else $error("SPI pins wrong"); // R16

    property p_rtc;
        @(posedge CLK) disable iff (!NRST) alt_enable[ALT_RTC]
            |=> !PORTD_DRV.oe_n[PD_TMR1_CLK] && PORTD_DRV.oe_n[PD_TMR2_CLK];
    endproperty
    a_rtc: assert property (p_rtc) else $error("RTC trim pins wrong"); // R17 R20

    property p_dir_c;
        @(posedge CLK) disable iff (!NRST) lcd_sel == 2'h0
            |=> PORTC_DRV.oe_n == ~$past(portc_direction);
    endproperty
    a_dir_c: assert property (p_dir_c) else $error("port C direction"); // R03
endmodule : gpcd_ports
`default_nettype wire

// ---- src/gpcd_pkg.sv ----
// Package for the port C / port D general-purpose I/O block.
// Assumes a byte-wide register port with one-cycle read latency.
package gpcd_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_PORTC_DATA = 8'h02; // Port C data latch
    localparam logic [7:0] ADDR_PORTD_DATA = 8'h03; // Port D data latch
    localparam logic [7:0] ADDR_PORTC_DIR = 8'h06; // Port C direction
    localparam logic [7:0] ADDR_PORTD_DIR = 8'h07; // Port D direction
    localparam logic [7:0] ADDR_PORTC_LED = 8'h0D; // Port C LED drive
    localparam logic [7:0] ADDR_OPTION_TWO = 8'h10; // LCD select bits
    localparam logic [7:0] ADDR_ALT_ENABLE = 8'h11; // Alternate function enables
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int OPT_LOWER_LCD = 0; // Port C pins 3..0 to LCD
    localparam int OPT_UPPER_LCD = 1; // Port C pins 7..4 to LCD
    localparam int ALT_I2C = 0; // I2C module enable
    localparam int ALT_SPI = 1; // SPI enable
    localparam int ALT_RTC = 2; // RTC trim enable
    localparam int ALT_T1 = 3; // Timer 1 external clock (prescale all ones)
    localparam int ALT_T2 = 4; // Timer 2 external clock
    localparam logic [7:0] RST_DIR = 8'h00; // Direction after reset
    localparam logic [7:0] RST_LED = 8'h00; // LED drive after reset
    localparam logic [7:0] RST_CFG = 8'h00; // Config after reset
    localparam int PIN_SYNC_STAGES = 3; // Input synchroniser depth
    // ----------------------------------------------------------------
    // Port D pin map of alternate functions
    // ----------------------------------------------------------------
    localparam int PD_SCK = 0; // SPI serial clock
    localparam int PD_MOSI = 1; // SPI MOSI
    localparam int PD_MISO = 2; // SPI MISO
    localparam int PD_SS = 3; // SPI slave select
    localparam int PD_SDA = 4; // I2C data, also keypad 4
    localparam int PD_SCL = 5; // I2C clock, also keypad 5
    localparam int PD_TMR1_CLK = 6; // Timer 1 clock / trim out, keypad 6
    localparam int PD_TMR2_CLK = 7; // Timer 2 clock / trim in, keypad 7
    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] val; // Level to drive
        logic [7:0] oe_n; // Low while the pin is driven
    } gpcd_pin_drv_s;
    typedef struct packed {
        logic [7:0] addr; // Register address
        logic [7:0] wdata; // Write data
        logic wr; // Write strobe
        logic rd; // Read strobe
    } gpcd_bus_s;
endpackage : gpcd_pkg

// ---- test/gpcd_pin_model.sv ----
// Behavioural model of the package pins of one eight-bit port.
// Assumes the block drives pins through a value/enable struct.
`timescale 1ns/1ns
`default_nettype none
module gpcd_pin_model (
    input wire logic CLK,
    input wire gpcd_pkg::gpcd_pin_drv_s DRV,
    input wire logic [7:0] EXT,
    input wire logic [7:0] EXT_OE,
    output logic [7:0] LEVEL
);
    import gpcd_pkg::*;
    // ------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------
    logic [7:0] last = 8'h00; // Previous resolved level
    // Remember the level so a floating line can wander
    always @(posedge CLK) begin
        last <= LEVEL;
    end
    // Block drive wins, then outside driver, else toggling float
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!DRV.oe_n[i]) begin
                LEVEL[i] = DRV.val[i];
            end else if (EXT_OE[i]) begin
                LEVEL[i] = EXT[i];
            end else begin
                LEVEL[i] = ~last[i];
            end
        end
    end
endmodule : gpcd_pin_model
`default_nettype wire

// ---- test/gpcd_ports_tb_top.sv ----
// Self-checking bench for the port C / port D I/O block.
// Assumes the pin models stand on both ports and the bench owns the bus.
`timescale 1ns/1ns
`default_nettype none
module gpcd_ports_tb_top;
    import gpcd_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic portd; // Row targets port D
        logic [7:0] dir; // Direction to set
        logic [7:0] latch; // Latch to write
        logic [7:0] pin; // Outside pin level
        logic [7:0] exp; // Expected data read
    } gpcd_row_s;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    gpcd_bus_s bus = '0;
    logic [7:0] rdata, pc_led, pd_level, pc_pin, pd_pin;
    logic [1:0] lcd_en;
    gpcd_pin_drv_s pc_drv, pd_drv;
    logic [7:0] pc_ext = 8'h00, pd_ext = 8'h00, pc_ext_oe = 8'hFF, pd_ext_oe = 8'hFF;
    logic [3:0] kbd_en = 4'h0;
    logic [2:0] t1_ps = 3'h0, t2_ps = 3'h0;
    logic sda_low = 1'b0, scl_low = 1'b0, trim_o = 1'b0;
    logic sck_o = 1'b0, sck_oe = 1'b0, mosi_o = 1'b0, mosi_oe = 1'b0, miso_o = 1'b0, miso_oe = 1'b0;
    int failures = 0;
    int samples_checked = 0;
    gpcd_row_s rows [8] = '{
        '{1'b0, 8'hFF, 8'hA5, 8'h3C, 8'hA5}, '{1'b0, 8'h00, 8'h5A, 8'hC3, 8'hC3},
        '{1'b0, 8'h0F, 8'h96, 8'h69, 8'h66}, '{1'b0, 8'hF0, 8'h00, 8'hFF, 8'h0F},
        '{1'b1, 8'h33, 8'hCC, 8'hAA, 8'h88}, '{1'b1, 8'hFF, 8'h81, 8'h00, 8'h81},
        '{1'b1, 8'h00, 8'h7E, 8'h18, 8'h18}, '{1'b1, 8'hAA, 8'hFF, 8'h00, 8'hAA}};
    // ------------------------------------------------------------
    // Design and pin models
    // ------------------------------------------------------------
    gpcd_ports dut (.CLK(clk), .NRST(nrst), .BUS(bus), .RDATA(rdata), .PORTC_IN(pc_pin),
        .PORTC_DRV(pc_drv), .PORTC_LED_SINK(pc_led), .LCD_NIBBLE_EN(lcd_en),
        .PORTD_IN(pd_pin), .PORTD_DRV(pd_drv), .KEYPAD_IRQ_ENABLE(kbd_en),
        .TIMER1_PRESCALE(t1_ps), .TIMER2_PRESCALE(t2_ps), .I2C_SDA_LOW(sda_low),
        .I2C_SCL_LOW(scl_low), .SPI_SCK_OUT(sck_o), .SPI_SCK_OE(sck_oe),
        .SPI_MOSI_OUT(mosi_o), .SPI_MOSI_OE(mosi_oe), .SPI_MISO_OUT(miso_o),
        .SPI_MISO_OE(miso_oe), .RTC_TRIM_OUT_VAL(trim_o), .PORTD_PIN_LEVEL(pd_level));
    gpcd_pin_model u_pc (.CLK(clk), .DRV(pc_drv), .EXT(pc_ext), .EXT_OE(pc_ext_oe),
        .LEVEL(pc_pin));
    gpcd_pin_model u_pd (.CLK(clk), .DRV(pd_drv), .EXT(pd_ext), .EXT_OE(pd_ext_oe),
        .LEVEL(pd_pin));
    // 100 MHz clock
    always #5 clk = ~clk;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Verdict and end of run
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    // Compare one byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr
    // One-cycle register read, data in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 d = rdata;
    endtask : rd
    // Let synchroniser and output registers catch up
    task automatic settle;
        repeat (8) @(posedge clk);
        #1;
    endtask : settle
    // Reset for ten cycles, then check reset state
    task automatic do_reset;
        logic [7:0] got;
        nrst <= 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk(pc_drv.oe_n, 8'hFF);
        chk(pd_drv.oe_n, 8'hFF);
        chk(pc_led, 8'h00);
        chk({6'h00, lcd_en}, 8'h00);
        chk(rdata, 8'h00);
        rd(ADDR_PORTC_DIR, got);
        chk(got, 8'h00);
        rd(ADDR_PORTD_DIR, got);
        chk(got, 8'h00);
        rd(ADDR_PORTC_LED, got);
        chk(got, 8'h00);
    endtask : do_reset
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        gpcd_row_s r;
        gpcd_pin_drv_s drv;
        logic [7:0] got, da, ra;
        do_reset();
        // Table of mixed direction, latch and pin values
        for (int i = 0; i < 8; i++) begin
            r = rows[i];
            da = r.portd ? ADDR_PORTD_DATA : ADDR_PORTC_DATA;
            ra = r.portd ? ADDR_PORTD_DIR : ADDR_PORTC_DIR;
            wr(da, r.latch);
            wr(ra, r.dir);
            if (r.portd) begin
                pd_ext <= r.pin;
                pd_ext_oe <= ~r.dir;
            end else begin
                pc_ext <= r.pin;
                pc_ext_oe <= ~r.dir;
            end
            settle();
            rd(da, got);
            chk(got, r.exp);
            drv = r.portd ? pd_drv : pc_drv;
            chk(drv.oe_n, ~r.dir);
            chk(drv.val & r.dir, r.latch & r.dir);
            rd(ra, got);
            chk(got, r.dir);
            if (r.portd) begin
                chk(pd_level, r.exp);
            end
        end
        // LED drive only on output pins
        wr(ADDR_PORTC_DIR, 8'h0F);
        wr(ADDR_PORTC_LED, 8'hFF);
        settle();
        chk(pc_led, 8'h0F);
        rd(ADDR_PORTC_LED, got);
        chk(got, 8'hFF);
        // LCD nibbles release port C pins
        wr(ADDR_PORTC_DIR, 8'hFF);
        wr(ADDR_OPTION_TWO, 8'h02);
        settle();
        chk({6'h00, lcd_en}, 8'h02);
        chk(pc_drv.oe_n, 8'hF0);
        wr(ADDR_OPTION_TWO, 8'h01);
        settle();
        chk({6'h00, lcd_en}, 8'h01);
        chk(pc_drv.oe_n, 8'h0F);
        wr(ADDR_OPTION_TWO, 8'h00);
        rd(8'h3F, got);
        chk(got, 8'h00);
        // Port D sharers, one at a time, with an I2C and keypad overlap
        wr(ADDR_PORTD_DATA, 8'hFF);
        wr(ADDR_PORTD_DIR, 8'hFF);
        pd_ext_oe <= 8'h00;
        kbd_en <= 4'hF;
        settle();
        chk(pd_drv.oe_n, 8'hF0);
        @(posedge clk);
        kbd_en <= 4'h0;
        t2_ps <= 3'h7;
        settle();
        chk(pd_drv.oe_n, 8'h80);
        @(posedge clk);
        t2_ps <= 3'h6;
        t1_ps <= 3'h7;
        settle();
        chk(pd_drv.oe_n, 8'h40);
        @(posedge clk);
        t1_ps <= 3'h0;
        sda_low <= 1'b1;
        wr(ADDR_ALT_ENABLE, 8'h01);
        settle();
        chk(pd_drv.oe_n, 8'h20);
        chk({7'h00, pd_drv.val[4]}, 8'h00);
        @(posedge clk);
        kbd_en <= 4'h1;
        settle();
        chk(pd_drv.oe_n, 8'h20);
        @(posedge clk);
        kbd_en <= 4'h0;
        sck_oe <= 1'b1;
        miso_oe <= 1'b1;
        wr(ADDR_ALT_ENABLE, 8'h02);
        settle();
        chk(pd_drv.oe_n, 8'h0A);
        chk({6'h00, pd_drv.val[2], pd_drv.val[0]}, 8'h00);
        wr(ADDR_ALT_ENABLE, 8'h04);
        settle();
        chk(pd_drv.oe_n, 8'h80);
        chk({7'h00, pd_drv.val[6]}, 8'h00);
        // Timer clock enables from the register; upper bits stay clear
        wr(ADDR_ALT_ENABLE, 8'hF8);
        settle();
        chk(pd_drv.oe_n, 8'hC0);
        rd(ADDR_ALT_ENABLE, got);
        chk(got, 8'h18);
        wr(ADDR_ALT_ENABLE, 8'h00);
        // Latches survive a reset in mid-run
        wr(ADDR_PORTC_DATA, 8'h5A);
        wr(ADDR_PORTD_DATA, 8'hA5);
        do_reset();
        wr(ADDR_PORTC_DIR, 8'hFF);
        wr(ADDR_PORTD_DIR, 8'hFF);
        rd(ADDR_PORTC_DATA, got);
        chk(got, 8'h5A);
        rd(ADDR_PORTD_DATA, got);
        chk(got, 8'hA5);
        finish_test();
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test();
    end
endmodule : gpcd_ports_tb_top
`default_nettype wire
